// >>> verilog/urb_top.sv
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module urb_top
(
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire urb_pkg::urb_bus_req_t bus_req,
  output logic [7:0]                 bus_rdata,
  input  wire logic                  rx_line,
  output logic                       tx_line,
  output logic                       rx_irq
);
  logic [4:0]             ctrl_r;
  logic [15:0]            baud_divisor;
  logic [1:0]             trig_r;
  logic [15:0]            ovs_cnt_r;
  logic [16:0]            brk_hold_r;
  logic                   brk_armed_r;
  urb_pkg::urb_tx_st_t    tx_st_r;
  logic [3:0]             tx_ph_r;
  logic [3:0]             tx_cnt_r;
  urb_pkg::urb_rx_st_t    rx_st_r;
  logic [3:0]             rx_ph_r;
  logic [3:0]             rx_bit_r;
  logic [2:0]             smp_r;
  logic [8:0]             rx_shift_reg;
  logic                   nz_r;
  logic                   ferr_r;
  logic [8:0]             fifo_mem [4];
  logic [1:0]             wptr_r;
  logic [1:0]             rptr_r;
  logic [2:0]             rx_fifo_count;
  logic                   overrun_flag;
  logic                   framing_error_flag;
  logic                   noise_flag;
  logic                   stat_seen_r;
  logic                   rx_irq_r;
  logic [7:0]             rdata_r;

  // Register decode
  wire wr_ctrl  = bus_req.wr && bus_req.addr == urb_pkg::ADDR_CTRL;
  wire wr_blo   = bus_req.wr && bus_req.addr == urb_pkg::ADDR_BAUD_LO;
  wire wr_bhi   = bus_req.wr && bus_req.addr == urb_pkg::ADDR_BAUD_HI;
  wire wr_trig  = bus_req.wr && bus_req.addr == urb_pkg::ADDR_TRIG;
  wire rd_stat  = bus_req.rd && bus_req.addr == urb_pkg::ADDR_STATUS;
  wire rd_data  = bus_req.rd && bus_req.addr == urb_pkg::ADDR_DATA;
  wire rx_enable         = ctrl_r[urb_pkg::CTL_RXEN];
  wire nine_bit_select   = ctrl_r[urb_pkg::CTL_NINE];
  wire rx_stop_count_sel = ctrl_r[urb_pkg::CTL_STOP2];
  wire break_request     = ctrl_r[urb_pkg::CTL_BRK];
  wire rx_irq_enable     = ctrl_r[urb_pkg::CTL_RIE];

  // 16x oversampling tick shared by both directions
  wire ovs_tick = ovs_cnt_r == baud_divisor;

  // Break transmitter; no transmit interrupt exists on this path
  wire tx_idle_flag = tx_st_r == urb_pkg::URB_TX_IDLE;
  wire tx_bit_tick  = ovs_tick && tx_ph_r == urb_pkg::OVS_LAST;
  wire brk_held     = brk_hold_r > {1'b0, baud_divisor};
  wire tx_zero_end  = tx_cnt_r == urb_pkg::BRK_LAST;

  // Receiver sampling and majority vote
  wire in_frame  = rx_st_r != urb_pkg::URB_RX_HUNT &&
                   rx_st_r != urb_pkg::URB_RX_BRKW;
  wire smp_win   = rx_ph_r >= urb_pkg::SMP_FIRST &&
                   rx_ph_r <= urb_pkg::SMP_LAST;
  wire bit_done  = ovs_tick && rx_ph_r == urb_pkg::OVS_LAST;
  wire vote      = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) |
                   (smp_r[1] & smp_r[2]);
  wire noisy     = !(smp_r == 3'h0 || smp_r == 3'h7);
  wire [3:0] last_bit = nine_bit_select ? urb_pkg::BITS9_LAST
                                        : urb_pkg::BITS8_LAST;
  wire stop_fail = !vote;
  wire fin_now   = bit_done && ((rx_st_r == urb_pkg::URB_RX_STOP1 &&
                   !rx_stop_count_sel) || rx_st_r == urb_pkg::URB_RX_STOP2);
  wire fin_ferr  = ferr_r | stop_fail;
  wire fin_noise = nz_r | noisy;
  // Eight-bit words sit one place high after eight shifts
  wire [8:0] rx_word = nine_bit_select ? rx_shift_reg
                                       : {1'b0, rx_shift_reg[8:1]};
  wire is_break  = fin_ferr && rx_word == 9'h000;
  wire rx_idle_flag = !in_frame;

  // Buffer control; a pop in the same cycle frees a slot
  wire pop      = rd_data && rx_fifo_count != 3'h0;
  wire full     = rx_fifo_count == urb_pkg::FIFO_DEPTH && !pop;
  wire push     = fin_now && !full;
  wire ovr_ev   = fin_now && full;
  wire clr_seq  = rd_data && stat_seen_r;
  wire [2:0] cnt_nxt = rx_fifo_count + {2'h0, push} - {2'h0, pop};
  wire [2:0] trig_lvl = {1'b0, trig_r} + 3'h1;
  wire irq_nxt  = rx_irq_enable &&
                  ((push && cnt_nxt >= trig_lvl) || ovr_ev);
  wire rx_data_avail_flag = rx_fifo_count != 3'h0;
  wire [8:0] head = fifo_mem[rptr_r];
  // Buffer slots hold no reset value, so an empty head reads as zero
  wire rx_ninth_bit = rx_data_avail_flag && head[8];

  wire [7:0] ctrl_rd = {rx_ninth_bit, 2'h0, ctrl_r};
  wire [7:0] stat_rd = {2'h0, !tx_idle_flag ? 1'b0 : 1'b1, rx_idle_flag,
                        noise_flag, framing_error_flag, overrun_flag,
                        rx_data_avail_flag};
  wire [7:0] rd_mux =
    bus_req.addr == urb_pkg::ADDR_CTRL    ? ctrl_rd :
    bus_req.addr == urb_pkg::ADDR_STATUS  ? stat_rd :
    bus_req.addr == urb_pkg::ADDR_DATA    ? (pop ? head[7:0] : 8'h00) :
    bus_req.addr == urb_pkg::ADDR_COUNT   ? {5'h00, rx_fifo_count} :
    bus_req.addr == urb_pkg::ADDR_BAUD_LO ? baud_divisor[7:0] :
    bus_req.addr == urb_pkg::ADDR_BAUD_HI ? baud_divisor[15:8] :
    bus_req.addr == urb_pkg::ADDR_TRIG    ? {6'h00, trig_r} : 8'h00;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ctrl_r       <= urb_pkg::CTRL_RST;
      baud_divisor <= urb_pkg::BAUD_RST;
      trig_r       <= urb_pkg::TRIG_RST;
      rdata_r      <= 8'h00;
      stat_seen_r  <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= bus_req.wdata[4:0];
      if (wr_blo)
        baud_divisor[7:0] <= bus_req.wdata;
      if (wr_bhi)
        baud_divisor[15:8] <= bus_req.wdata;
      if (wr_trig)
        trig_r <= bus_req.wdata[1:0];
      rdata_r <= bus_req.rd ? rd_mux : 8'h00;
      if (rd_stat)
        stat_seen_r <= 1'b1;
      else if (rd_data)
        stat_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst || ovs_tick)
      ovs_cnt_r <= 16'h0000;
    else
      ovs_cnt_r <= ovs_cnt_r + 16'h0001;
  end

  // Hold time counted only while idle; saturates at divisor+1, one clock before arming
  always_ff @(posedge core_clk)
  begin
    if (!nrst || !break_request || !tx_idle_flag)
      brk_hold_r <= 17'h00000;
    else if (!brk_held)
      brk_hold_r <= brk_hold_r + 17'h00001;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      tx_st_r     <= urb_pkg::URB_TX_IDLE;
      tx_ph_r     <= 4'h0;
      tx_cnt_r    <= 4'h0;
      brk_armed_r <= 1'b0;
    end
    else
    begin
      if (tx_idle_flag && brk_held)
        brk_armed_r <= 1'b1;
      if (ovs_tick && !tx_idle_flag)
        tx_ph_r <= tx_ph_r + 4'h1;
      case (tx_st_r)
        urb_pkg::URB_TX_IDLE:
          if (brk_armed_r && ovs_tick)
          begin
            tx_st_r     <= urb_pkg::URB_TX_START;
            tx_ph_r     <= 4'h0;
            brk_armed_r <= 1'b0;
          end
        urb_pkg::URB_TX_START:
          if (tx_bit_tick)
          begin
            tx_st_r  <= urb_pkg::URB_TX_ZERO;
            tx_cnt_r <= 4'h0;
          end
        urb_pkg::URB_TX_ZERO:
          if (tx_bit_tick)
          begin
            tx_cnt_r <= tx_zero_end ? 4'h0 : tx_cnt_r + 4'h1;
            if (tx_zero_end && !break_request)
              tx_st_r <= urb_pkg::URB_TX_STOP;
          end
        urb_pkg::URB_TX_STOP:
          if (tx_bit_tick)
          begin
            tx_cnt_r <= tx_cnt_r + 4'h1;
            if (tx_cnt_r[1:0] == urb_pkg::TX_STOPS_LAST)
              tx_st_r <= urb_pkg::URB_TX_IDLE;
          end
        default:
          tx_st_r <= urb_pkg::URB_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      tx_line <= 1'b1;
    else
      tx_line <= tx_st_r == urb_pkg::URB_TX_IDLE ||
                 tx_st_r == urb_pkg::URB_TX_STOP;
  end

  // Dropping the enable aborts the frame; the buffer is kept
  always_ff @(posedge core_clk)
  begin
    if (!nrst || !rx_enable)
    begin
      rx_st_r      <= urb_pkg::URB_RX_HUNT;
      rx_ph_r      <= 4'h0;
      rx_bit_r     <= 4'h0;
      smp_r        <= 3'h7;
      rx_shift_reg <= 9'h000;
      nz_r         <= 1'b0;
      ferr_r       <= 1'b0;
    end
    else if (ovs_tick)
    begin
      rx_ph_r <= rx_ph_r + 4'h1;
      if (smp_win)
        smp_r <= {smp_r[1:0], rx_line};
      case (rx_st_r)
        urb_pkg::URB_RX_HUNT:
          if (!rx_line)
          begin
            rx_st_r <= urb_pkg::URB_RX_START;
            rx_ph_r <= 4'h0;
            nz_r    <= 1'b0;
            ferr_r  <= 1'b0;
          end
        urb_pkg::URB_RX_START:
          if (bit_done)
          begin
            rx_st_r  <= vote ? urb_pkg::URB_RX_HUNT : urb_pkg::URB_RX_DATA;
            rx_bit_r <= 4'h0;
            nz_r     <= noisy;
          end
        urb_pkg::URB_RX_DATA:
          if (bit_done)
          begin
            rx_shift_reg <= {vote, rx_shift_reg[8:1]};
            nz_r         <= fin_noise;
            rx_bit_r     <= rx_bit_r + 4'h1;
            if (rx_bit_r == last_bit)
              rx_st_r <= urb_pkg::URB_RX_STOP1;
          end
        urb_pkg::URB_RX_STOP1, urb_pkg::URB_RX_STOP2:
          if (bit_done)
          begin
            ferr_r <= fin_ferr;
            nz_r   <= fin_noise;
            if (!fin_now)
              rx_st_r <= urb_pkg::URB_RX_STOP2;
            else if (is_break)
              rx_st_r <= urb_pkg::URB_RX_BRKW;
            else
              rx_st_r <= urb_pkg::URB_RX_HUNT;
          end
        urb_pkg::URB_RX_BRKW:
          if (rx_line)
            rx_st_r <= urb_pkg::URB_RX_HUNT;
        default:
          rx_st_r <= urb_pkg::URB_RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      fifo_mem[wptr_r] <= rx_word;
  end

  // Hardware set wins over the software clear sequence
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      wptr_r             <= 2'h0;
      rptr_r             <= 2'h0;
      rx_fifo_count      <= 3'h0;
      overrun_flag       <= 1'b0;
      framing_error_flag <= 1'b0;
      noise_flag         <= 1'b0;
      rx_irq_r           <= 1'b0;
    end
    else
    begin
      if (push)
        wptr_r <= wptr_r + 2'h1;
      if (pop)
        rptr_r <= rptr_r + 2'h1;
      rx_fifo_count <= cnt_nxt;
      overrun_flag  <= ovr_ev || (overrun_flag && !clr_seq);
      framing_error_flag <= (fin_now && fin_ferr) ||
                            (framing_error_flag && !clr_seq);
      noise_flag <= (push && fin_noise) ||
                    (noise_flag && !clr_seq);
      rx_irq_r <= irq_nxt;
    end
  end

  assign bus_rdata = rdata_r;
  assign rx_irq    = rx_irq_r;

  a_idle_in_frame: assert property (@(posedge core_clk)
    disable iff (!nrst) rd_stat && rx_st_r == urb_pkg::URB_RX_DATA
    |=> !bus_rdata[urb_pkg::ST_RIDLE])
    else $error("idle flag high during data bits");
  a_fifo_bound: assert property (@(posedge core_clk)
    disable iff (!nrst) rx_fifo_count <= urb_pkg::FIFO_DEPTH)
    else $error("buffer count above depth");
  a_overrun_keeps: assert property (@(posedge core_clk)
    disable iff (!nrst)
    ovr_ev |=> overrun_flag && rx_fifo_count == $past(rx_fifo_count))
    else $error("overrun lost flag or changed buffer");
  a_pop_count: assert property (@(posedge core_clk)
    disable iff (!nrst)
    pop && !push |=> rx_fifo_count == $past(rx_fifo_count) - 3'h1)
    else $error("read did not decrement count");
  a_push_avail: assert property (@(posedge core_clk)
    disable iff (!nrst) push |=> rx_data_avail_flag)
    else $error("avail flag missing after push");
  a_overrun_irq: assert property (@(posedge core_clk)
    disable iff (!nrst) ovr_ev && rx_irq_enable |=> rx_irq)
    else $error("overrun gave no interrupt");
  a_break_low: assert property (@(posedge core_clk)
    disable iff (!nrst) tx_st_r == urb_pkg::URB_TX_ZERO ##1
    tx_st_r == urb_pkg::URB_TX_ZERO |-> !tx_line)
    else $error("line high inside break");
  a_break_len: assert property (@(posedge core_clk)
    disable iff (!nrst) $rose(tx_st_r == urb_pkg::URB_TX_STOP)
    |-> $past(tx_cnt_r) == urb_pkg::BRK_LAST)
    else $error("break ended off a 13-bit boundary");
  a_brk_wait_low: assert property (@(posedge core_clk)
    disable iff (!nrst) rx_st_r == urb_pkg::URB_RX_BRKW && !rx_line &&
    rx_enable |=> rx_st_r == urb_pkg::URB_RX_BRKW)
    else $error("low line after break taken as start");
  a_noise_flag: assert property (@(posedge core_clk)
    disable iff (!nrst)
    push && fin_noise |=> noise_flag ##0 rx_data_avail_flag)
    else $error("noisy word without noise flag");

  c_overrun:  cover property (@(posedge core_clk) disable iff (!nrst) ovr_ev);
  c_rx_break: cover property (@(posedge core_clk) disable iff (!nrst)
    fin_now && is_break);
  c_tx_break: cover property (@(posedge core_clk) disable iff (!nrst)
    $rose(tx_st_r == urb_pkg::URB_TX_STOP));
  c_trig_irq: cover property (@(posedge core_clk) disable iff (!nrst)
    push && irq_nxt);
endmodule // urb_top

// >>> verilog/urb_pkg.sv
// How it works
// - Break armed after held past divisor+1 clocks
// - Break: start bit, 13*N zeros, stop bits
// - Repeat breaks; on release finish, two stops
// - Break sending raises no transmit interrupt
// - Nine-bit mode keeps MSB in ninth-bit field
// - Recovery at 16x baud, shifter per bit
// - Each bit decided by three-sample majority
// - Receive data shifted in LSB first
// - Four buffered words; fifth completing is dropped
// - Enabled receiver hunts for start bit
// - Avail flag when buffered; count register readable
// - Push reaching trigger level raises receive irq
// - Break completes frame, flags, stores zero word
// - After break wait stop bit, no restart
// - Idle low from start to end of last stop bit
// - Overrun also raises receive irq
// - Overrun keeps buffer, shift register overwritten
// - Noise flag set on push, word kept
// - Zero stop bit sets framing error flag
package urb_pkg;
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_STATUS   = 4'h1;
  localparam logic [3:0]  ADDR_DATA     = 4'h2;
  localparam logic [3:0]  ADDR_COUNT    = 4'h3;
  localparam logic [3:0]  ADDR_BAUD_LO  = 4'h4;
  localparam logic [3:0]  ADDR_BAUD_HI  = 4'h5;
  localparam logic [3:0]  ADDR_TRIG     = 4'h6;
  localparam int          CTL_RXEN      = 0;
  localparam int          CTL_NINE      = 1;
  localparam int          CTL_STOP2     = 2;
  localparam int          CTL_BRK       = 3;
  localparam int          CTL_RIE       = 4;
  localparam int          CTL_RX8       = 7;
  localparam int          ST_AVAIL      = 0;
  localparam int          ST_OVR        = 1;
  localparam int          ST_FERR       = 2;
  localparam int          ST_NOISE      = 3;
  localparam int          ST_RIDLE      = 4;
  localparam int          ST_TIDLE      = 5;
  localparam logic [15:0] BAUD_RST      = 16'h0000;
  localparam logic [4:0]  CTRL_RST      = 5'h00;
  localparam logic [1:0]  TRIG_RST      = 2'h0;
  localparam logic [3:0]  OVS_LAST      = 4'hF;
  localparam logic [3:0]  SMP_FIRST     = 4'h7;
  localparam logic [3:0]  SMP_LAST      = 4'h9;
  localparam logic [3:0]  BRK_LAST      = 4'hC;
  localparam logic [3:0]  BITS8_LAST    = 4'h7;
  localparam logic [3:0]  BITS9_LAST    = 4'h8;
  localparam logic [2:0]  FIFO_DEPTH    = 3'h4;
  localparam logic [1:0]  TX_STOPS_LAST = 2'h1;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } urb_bus_req_t;

  typedef enum logic [1:0] {URB_TX_IDLE, URB_TX_START, URB_TX_ZERO,
                            URB_TX_STOP} urb_tx_st_t;
  typedef enum logic [2:0] {URB_RX_HUNT, URB_RX_START, URB_RX_DATA,
                            URB_RX_STOP1, URB_RX_STOP2,
                            URB_RX_BRKW} urb_rx_st_t;
endpackage

// >>> sim/urb_remote.sv
`timescale 1ns/1ps
module urb_remote
(
  input  wire logic core_clk,
  output logic      rx_line,
  input  wire logic tx_line
);
  int bit_clks;
  int low_run;
  int run_cnt;

  // Idle line is high, as behind a pull-up
  initial
  begin
    rx_line  = 1'b1;
    bit_clks = 16;
    low_run  = 0;
    run_cnt  = 0;
  end

  // Length of the last low stretch on the break output
  always @(posedge core_clk)
  begin
    if (tx_line === 1'b0)
      run_cnt <= run_cnt + 1;
    else if (run_cnt != 0)
    begin
      low_run <= run_cnt;
      run_cnt <= 0;
    end
  end

  task automatic hold(input logic lvl, input int n);
    rx_line <= lvl;
    repeat (n) @(posedge core_clk);
  endtask

  // One frame LSB first the glitch spans one tick in the middle
  // of bit 0 so exactly one of the three votes is hit
  task automatic send(input logic [8:0] w, input int nb,
                      input logic stp, input logic glitch);
    int t;
    t = bit_clks / 16;
    hold(1'b0, bit_clks);
    for (int i = 0; i < nb; i++)
    begin
      if (glitch && i == 0)
      begin
        hold(w[0], 8 * t);
        hold(~w[0], t);
        hold(w[0], bit_clks - 9 * t);
      end
      else
        hold(w[i], bit_clks);
    end
    hold(stp, bit_clks);
    if (!stp)
      hold(1'b1, bit_clks);
  endtask
endmodule // urb_remote

// >>> sim/urb_top_bench.sv
`timescale 1ns/1ps
module urb_top_bench;
  logic                  core_clk;
  logic                  nrst;
  urb_pkg::urb_bus_req_t req;
  logic [7:0]            bus_rdata;
  logic                  rx_line;
  logic                  tx_line;
  logic                  rx_irq;
  int                    err_total;
  int                    checks_done;
  int                    irq_cnt;
  int                    base;
  int                    low_exp;

  urb_top DUT (.core_clk(core_clk), .nrst(nrst), .bus_req(req),
    .bus_rdata(bus_rdata), .rx_line(rx_line), .tx_line(tx_line),
    .rx_irq(rx_irq));
  urb_remote u_rem (.core_clk(core_clk), .rx_line(rx_line),
    .tx_line(tx_line));

  always #4 core_clk = ~core_clk;

  always @(posedge core_clk)
    if (rx_irq === 1'b1)
      irq_cnt <= irq_cnt + 1;

  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    v = bus_rdata;
    check(nm, {8'h00, e}, {8'h00, v & m});
    @(posedge core_clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    err_total++;
    give_verdict();
  end

  initial
  begin
    core_clk    = 1'b0;
    nrst        = 1'b0;
    req         = '0;
    err_total   = 0;
    checks_done = 0;
    irq_cnt     = 0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rchk("ctrl_rst", urb_pkg::ADDR_CTRL, 8'hFF, 8'h00);
    rchk("count_rst", urb_pkg::ADDR_COUNT, 8'hFF, 8'h00);
    wreg(4'hF, 8'hFF);
    rchk("unmapped", 4'hF, 8'hFF, 8'h00);
    check("tx_rst", 16'h0001, {15'h0000, tx_line});
    // Divisor 2: one bit is 48 clocks
    wreg(urb_pkg::ADDR_BAUD_LO, 8'h02);
    wreg(urb_pkg::ADDR_CTRL, 8'h11);
    u_rem.bit_clks = 48;
    fork
      u_rem.send(9'h0A5, 8, 1'b1, 1'b0);
      begin
        repeat (200) @(posedge core_clk);
        rchk("idle_busy", urb_pkg::ADDR_STATUS, 8'h10, 8'h00);
      end
    join
    repeat (4) @(posedge core_clk);
    rchk("st_word", urb_pkg::ADDR_STATUS, 8'h1F, 8'h11);
    rchk("cnt_one", urb_pkg::ADDR_COUNT, 8'hFF, 8'h01);
    check("irq_one", 16'h0001, 16'(irq_cnt));
    rchk("data_a5", urb_pkg::ADDR_DATA, 8'hFF, 8'hA5);
    rchk("st_clr", urb_pkg::ADDR_STATUS, 8'h1F, 8'h10);
    rchk("cnt_pop", urb_pkg::ADDR_COUNT, 8'hFF, 8'h00);
    u_rem.send(9'h03C, 8, 1'b1, 1'b1);
    repeat (4) @(posedge core_clk);
    rchk("st_noise", urb_pkg::ADDR_STATUS, 8'h1F, 8'h19);
    check("irq_noise", 16'h0002, 16'(irq_cnt));
    rchk("data_3c", urb_pkg::ADDR_DATA, 8'hFF, 8'h3C);
    rchk("noise_clr", urb_pkg::ADDR_STATUS, 8'h1F, 8'h10);
    u_rem.send(9'h055, 8, 1'b0, 1'b0);
    rchk("st_ferr", urb_pkg::ADDR_STATUS, 8'h1F, 8'h15);
    rchk("data_55", urb_pkg::ADDR_DATA, 8'hFF, 8'h55);
    // Two stops: the ninth bit sent is a good first stop, the second is low
    wreg(urb_pkg::ADDR_CTRL, 8'h15);
    u_rem.send(9'h1C3, 9, 1'b0, 1'b0);
    rchk("st_stop2", urb_pkg::ADDR_STATUS, 8'h1F, 8'h15);
    rchk("data_c3", urb_pkg::ADDR_DATA, 8'hFF, 8'hC3);
    wreg(urb_pkg::ADDR_CTRL, 8'h13);
    u_rem.send(9'h1A5, 9, 1'b1, 1'b0);
    repeat (4) @(posedge core_clk);
    rchk("ninth", urb_pkg::ADDR_CTRL, 8'h80, 8'h80);
    rchk("data_9b", urb_pkg::ADDR_DATA, 8'hFF, 8'hA5);
    // Trigger at four words, then a fifth arrives unread
    wreg(urb_pkg::ADDR_CTRL, 8'h11);
    wreg(urb_pkg::ADDR_TRIG, 8'h03);
    base = irq_cnt;
    for (int i = 1; i <= 5; i++)
      u_rem.send(9'(i), 8, 1'b1, 1'b0);
    // Back-to-back frames drift by a tick each, so the last push lags
    repeat (20) @(posedge core_clk);
    check("irq_ovr", 16'h0002, 16'(irq_cnt - base));
    rchk("cnt_full", urb_pkg::ADDR_COUNT, 8'hFF, 8'h04);
    rchk("st_ovr", urb_pkg::ADDR_STATUS, 8'h1F, 8'h13);
    for (int i = 1; i <= 4; i++)
      rchk("data_kept", urb_pkg::ADDR_DATA, 8'hFF, 8'(i));
    rchk("data_empty", urb_pkg::ADDR_DATA, 8'hFF, 8'h00);
    rchk("ovr_clr", urb_pkg::ADDR_STATUS, 8'h1F, 8'h10);
    wreg(urb_pkg::ADDR_CTRL, 8'h10);
    wreg(urb_pkg::ADDR_CTRL, 8'h11);
    wreg(urb_pkg::ADDR_TRIG, 8'h00);
    // Long low line: one zero word, no restart until the line is high
    u_rem.hold(1'b0, 20 * 48);
    u_rem.hold(1'b1, 3 * 48);
    rchk("cnt_brk", urb_pkg::ADDR_COUNT, 8'hFF, 8'h01);
    rchk("st_brk", urb_pkg::ADDR_STATUS, 8'h1F, 8'h15);
    rchk("data_brk", urb_pkg::ADDR_DATA, 8'hFF, 8'h00);
    // Break output: released at once, then held into a second group
    for (int k = 0; k < 2; k++)
    begin
      base = irq_cnt;
      wreg(urb_pkg::ADDR_CTRL, 8'h19);
      for (int i = 0; i < 400 && tx_line !== 1'b0; i++)
        @(posedge core_clk);
      check("brk_start", 16'h0000, {15'h0000, tx_line});
      repeat (k * 20 * 48) @(posedge core_clk);
      wreg(urb_pkg::ADDR_CTRL, 8'h11);
      for (int i = 0; i < 2000 && tx_line !== 1'b1; i++)
        @(posedge core_clk);
      repeat (110) @(posedge core_clk);
      low_exp = (k == 0 ? 14 : 27) * 48;
      check("brk_len", 16'(low_exp), 16'(u_rem.low_run));
      check("brk_high", 16'h0001, {15'h0000, tx_line});
      check("brk_noirq", 16'h0000, 16'(irq_cnt - base));
      rchk("tx_idle", urb_pkg::ADDR_STATUS, 8'h20, 8'h20);
    end
    give_verdict();
  end
endmodule // urb_top_bench
